// ---- bct_cell_balance_timers.sv ----
// Countdown timers for balancing channels nine to eleven with an AXI4-Lite slave.
// Assumes a one-cycle ten-second tick and the enables come from the balancing unit.
// Behaviour
// - Bits 15 and 14 of every timer register read zero and ignore writes.
// - Bits 13 to 0 hold the duration; reads return the live count.
// - The count saturates at zero and never wraps.
// - A zero count stops balancing on that channel, however it got there.
// - Counting runs only with global, timer and channel enables all set.
// - One count unit is ten seconds of balancing.
// - Each duration field resets to zero, the time_elapsed_code state.
// - All ones, 3FFF, is accepted as the longest duration.
// - Channel nine, ten and eleven registers sit at consecutive addresses.
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/100ps

module bct_cell_balance_timers
  import bct_pkg::*;
(
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  input  wire logic [ADDR_WIDTH-1:0]        s_axi_awaddr,
  input  wire logic [2:0]                   s_axi_awprot,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [31:0]                  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic [ADDR_WIDTH-1:0]        s_axi_araddr,
  input  wire logic [2:0]                   s_axi_arprot,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic [31:0]                       s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  input  wire logic                         tick_ten_seconds,
  input  wire logic                         global_balance_enable,
  input  wire logic                         timer_balance_enable,
  input  wire logic [CHAN_COUNT-1:0]        channel_enable,
  output logic [CHAN_COUNT-1:0]             balance_allow
);

  // Byte address of a timer register from its word index.
  function automatic logic [ADDR_WIDTH-1:0] reg_addr(
    input logic [15:0] idx
  );
    return ADDR_WIDTH'({idx, ADDR_SHIFT'(0)});
  endfunction

  // One-hot channel select for a byte address; zero when unmapped.
  function automatic logic [CHAN_COUNT-1:0] chan_decode(
    input logic [ADDR_WIDTH-1:0] addr
  );
    logic [CHAN_COUNT-1:0] hit;
    hit = '0;
    if (addr == reg_addr(IDX_CHAN_NINE))
    begin
      hit[0] = 1'b1;
    end
    if (addr == reg_addr(IDX_CHAN_TEN))
    begin
      hit[1] = 1'b1;
    end
    if (addr == reg_addr(IDX_CHAN_ELEVEN))
    begin
      hit[2] = 1'b1;
    end
    return hit;
  endfunction

  // Low byte strobe covers field bits 7 to 0.
  function automatic logic lane_lo(
    input logic [3:0] strb
  );
    return strb[0];
  endfunction

  // High byte strobe covers field bits 13 to 8.
  function automatic logic lane_hi(
    input logic [3:0] strb
  );
    return strb[1];
  endfunction

  // Merges the written byte lanes over the held count; bits 15 and 14 are dropped.
  function automatic logic [COUNT_WIDTH-1:0] lane_merge(
    input logic [COUNT_WIDTH-1:0] old_count,
    input logic [31:0]            data,
    input logic [3:0]             strb
  );
    logic [COUNT_WIDTH-1:0] merged;
    merged = old_count;
    if (lane_lo(strb))
    begin
      merged[7:0] = data[7:0];
    end
    if (lane_hi(strb))
    begin
      merged[COUNT_WIDTH-1:8] = data[COUNT_WIDTH-1:8];
    end
    return merged;
  endfunction

  // Mapped addresses answer okay, all others a slave error.
  function automatic logic [1:0] resp_code(
    input logic [CHAN_COUNT-1:0] hit
  );
    return (|hit) ? RESP_OKAY : RESP_SLVERR;
  endfunction

  bct_wreq_type            wreq_q;
  logic                    aw_held_q;
  logic                    w_held_q;
  logic                    bvalid_q;
  logic [1:0]              bresp_q;
  logic                    rvalid_q;
  logic [1:0]              rresp_q;
  logic [31:0]             rdata_q;
  bct_chan_type            chan_q [CHAN_COUNT];

  wire                     aw_take;
  wire                     w_take;
  wire                     wr_fire;
  wire                     ar_take;
  wire [CHAN_COUNT-1:0]    wr_map;
  wire [CHAN_COUNT-1:0]    wr_hit;
  wire [CHAN_COUNT-1:0]    allow_all;
  wire [CHAN_COUNT-1:0]    rd_hit;
  wire                     run_common;
  logic [COUNT_WIDTH-1:0]  rd_count;

  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready = !w_held_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign balance_allow = allow_all;

  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign wr_map = chan_decode(wreq_q.addr);
  assign wr_hit = wr_fire ? wr_map : '0;
  assign rd_hit = chan_decode(s_axi_araddr);
  assign run_common = global_balance_enable && timer_balance_enable;

  always_comb
  begin
    rd_count = COUNT_RESET;
    for (int i = 0; i < CHAN_COUNT; i++)
    begin
      if (rd_hit[i])
      begin
        rd_count = chan_q[i].count;
      end
    end
  end

  // Write address and data are captured in either order.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wreq_q <= '0;
    end
    else
    begin
      if (aw_take)
      begin
        wreq_q.addr <= s_axi_awaddr;
      end
      if (w_take)
      begin
        wreq_q.data <= s_axi_wdata;
        wreq_q.strb <= s_axi_wstrb;
      end
    end
  end

  // Both halves are released together once the write commits.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
    end
    else
    begin
      aw_held_q <= wr_fire ? 1'b0 : (aw_held_q || aw_take);
      w_held_q <= wr_fire ? 1'b0 : (w_held_q || w_take);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_q <= 1'b0;
    end
    else if (wr_fire)
    begin
      bvalid_q <= 1'b1;
    end
    else if (s_axi_bready)
    begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bresp_q <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bresp_q <= resp_code(wr_map);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
    end
    else if (ar_take)
    begin
      rvalid_q <= 1'b1;
    end
    else if (s_axi_rready)
    begin
      rvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rresp_q <= RESP_OKAY;
      rdata_q <= '0;
    end
    else if (ar_take)
    begin
      rresp_q <= resp_code(rd_hit);
      rdata_q <= 32'({RESERVED_BITS, rd_count});
    end
  end

  for (genvar g = 0; g < CHAN_COUNT; g++)
  begin : g_chan
    wire                    run;
    wire                    nonzero;
    wire                    step;
    wire                    allow_d;
    wire [COUNT_WIDTH-1:0]  wr_value;
    logic [COUNT_WIDTH-1:0] count_d;

    assign run = run_common && channel_enable[g];
    assign nonzero = chan_q[g].count != TIME_ELAPSED_CODE;
    assign step = tick_ten_seconds && run && nonzero;
    assign wr_value = lane_merge(chan_q[g].count, wreq_q.data, wreq_q.strb);
    assign allow_d = count_d != TIME_ELAPSED_CODE;
    assign allow_all[g] = chan_q[g].allow;

    always_comb
    begin
      count_d = chan_q[g].count;
      if (wr_hit[g])
      begin
        count_d = wr_value;
      end
      else if (step)
      begin
        count_d = chan_q[g].count - COUNT_STEP;
      end
    end

    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        chan_q[g].count <= COUNT_RESET;
        chan_q[g].allow <= 1'b0;
      end
      else
      begin
        chan_q[g].count <= count_d;
        chan_q[g].allow <= allow_d;
      end
    end
  end

endmodule

// ---- bct_pkg.sv ----
// Constants and types for the cell balancing countdown timers.
// Assumes a 32-bit AXI4-Lite register bus and an external ten-second tick.
package bct_pkg;

  localparam int CHAN_COUNT = 3;
  localparam int COUNT_WIDTH = 14;
  localparam int REG_WIDTH = 16;

  localparam logic [15:0] IDX_CHAN_NINE = 16'h1029;
  localparam logic [15:0] IDX_CHAN_TEN = 16'h102A;
  localparam logic [15:0] IDX_CHAN_ELEVEN = 16'h102B;
  localparam int ADDR_SHIFT = 2;
  localparam int ADDR_WIDTH = 18;

  localparam logic [13:0] COUNT_RESET = 14'h0000;
  localparam logic [13:0] TIME_ELAPSED_CODE = 14'h0000;
  localparam logic [13:0] COUNT_STEP = 14'h0001;
  localparam logic [13:0] COUNT_MAX = 14'h3FFF;
  localparam logic [1:0] RESERVED_BITS = 2'h0;

  localparam int UNIT_SECONDS = 10;
  localparam int MAX_SECONDS = 163830;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [ADDR_WIDTH-1:0] addr;
    logic [31:0]           data;
    logic [3:0]            strb;
  } bct_wreq_type;

  typedef struct packed {
    logic [COUNT_WIDTH-1:0] count;
    logic                   allow;
  } bct_chan_type;

endpackage

// ---- bct_cell_balance_timers_assertions.sv ----
// Port-level checker for the cell balancing countdown timers.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/100ps
module bct_checker
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        tick_ten_seconds,
  input wire logic        global_balance_enable,
  input wire logic        timer_balance_enable,
  input wire logic [2:0]  balance_allow
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_read_reserved: assert property (s_axi_rvalid |-> s_axi_rdata[31:14] == 18'h0)
    else $error("Reserved bits read nonzero.");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("Read not answered.");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
    else $error("Read data changed.");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##2 s_axi_bvalid) else $error("Write not answered.");
  a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("Write taken while busy.");
  a_allow_hold: assert property (!$past(tick_ten_seconds && global_balance_enable &&
    timer_balance_enable) && !$rose(s_axi_bvalid) |-> $stable(balance_allow))
    else $error("Allow changed without cause.");
  a_allow_rise: assert property ((balance_allow & ~$past(balance_allow)) != 3'h0
    |-> $rose(s_axi_bvalid)) else $error("Allow rose without write.");
  a_allow_fall: assert property ((~balance_allow & $past(balance_allow)) != 3'h0
    |-> $rose(s_axi_bvalid) || $past(tick_ten_seconds)) else $error("Allow fell alone.");
endmodule

bind bct_cell_balance_timers bct_checker u_chk (.*);

// ---- bct_cell_balance_timers_tb.sv ----
// Self-checking bench for the cell balancing countdown timers.
// Assumes the timer block and its checker are compiled beforehand.
`timescale 1ns/100ps
module bct_cell_balance_timers_tb
  import bct_pkg::*;
;
  logic        aclk = '0, aresetn = '0, s_axi_awvalid = '0, s_axi_wvalid = '0;
  logic        s_axi_bready = '0, s_axi_arvalid = '0, s_axi_rready = '0;
  logic        tick_ten_seconds = '0, global_balance_enable = '0, timer_balance_enable = '0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [17:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, r = 32'h1394;
  logic [3:0]  s_axi_wstrb = '0;
  logic [2:0]  s_axi_awprot = '0, s_axi_arprot = '0, channel_enable = '0, balance_allow;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [13:0] m [4] = '{default: '0};
  int          n_fail = 0, checked = 0, cyc = 0, c;

  bct_cell_balance_timers u_dut (.*);

  initial forever #50 aclk = ~aclk;

  function automatic logic [31:0] nx();
    r ^= r << 13;
    r ^= r >> 17;
    r ^= r << 5;
    return r;
  endfunction

  task automatic results();
    if (n_fail == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string nm);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input int k, input logic [31:0] d, input logic [3:0] s, input logic t);
    logic a, w;
    a = 1'h1;
    w = 1'h1;
    s_axi_awaddr <= {IDX_CHAN_NINE + 16'(k), 2'h0};
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (a || w)
    begin
      @(posedge aclk);
      if (a && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (w && s_axi_wready) s_axi_wvalid <= 1'h0;
      a &= !s_axi_awready;
      w &= !s_axi_wready;
    end
    tick_ten_seconds <= t;
    @(posedge aclk);
    tick_ten_seconds <= 1'h0;
    for (int i = 0; i < 3; i++)
      if (t && &{global_balance_enable, timer_balance_enable, channel_enable[i]} && m[i] != 0 && i != k)
        m[i]--;
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    if (k < 3 && s[0]) m[k][7:0] = d[7:0];
    if (k < 3 && s[1]) m[k][13:8] = d[13:8];
    chk(32'(s_axi_bresp), 32'(k < 3 ? RESP_OKAY : RESP_SLVERR), "bresp");
  endtask

  task automatic rd(input int k);
    s_axi_araddr <= {IDX_CHAN_NINE + 16'(k), 2'h0};
    s_axi_arvalid <= 1'h1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    chk(s_axi_rdata, {18'h0, m[k]}, "rdata");
    chk(32'(s_axi_rresp), 32'(k < 3 ? RESP_OKAY : RESP_SLVERR), "rresp");
    chk(32'(balance_allow), 32'({m[2] != 0, m[1] != 0, m[0] != 0}), "allow");
  endtask

  task automatic tk();
    logic [4:0] e;
    e = 5'(nx() | nx());
    {global_balance_enable, timer_balance_enable, channel_enable} <= e;
    tick_ten_seconds <= 1'h1;
    @(posedge aclk);
    tick_ten_seconds <= 1'h0;
    for (int i = 0; i < 3; i++)
      if (&e[4:3] && e[i] && m[i] != 0) m[i]--;
  endtask

  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      results();
    end
  end

  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    for (int i = 0; i < 4; i++) rd(i);
    wr(0, 32'hFFFFFFFF, 4'hF, 1'h0);
    rd(0);
    tk();
    rd(0);
    wr(1, 32'h00000003, 4'h3, 1'h1);
    rd(1);
    repeat (150)
    begin
      c = int'(nx() % 4);
      if (r[8]) wr(c, nx() & 32'hFFFFC007, 4'(nx()), r[3]);
      else tk();
      rd(c);
    end
    aresetn <= 1'h0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    m = '{default: '0};
    for (int i = 0; i < 3; i++) rd(i);
    results();
  end
endmodule
